// ===== logic/sis_adc_ctl.sv
`timescale 1ns/1ps
`default_nettype none
module sis_adc_ctl
  import sis_pkg::*;
#(
  parameter int unsigned CONV_CYCLES = CONV_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Converter
  input wire logic [11:0] adc_sample,
  sis_conv_if.ctl cif
);
  localparam int unsigned NW = $clog2(CONV_CYCLES + 1);
  typedef struct packed {
    logic [NW-1:0] cnt;
    logic done;
    logic [11:0] result;
  } sis_adc_state_type;
  sis_adc_state_type q, d;
  always_comb begin
    d = q;
    if (cif.start) begin
      d.cnt = NW'(CONV_CYCLES);
      d.done = 1'b0;
    end else if (q.cnt != '0 && !cif.calib_busy) begin
      // Conversion waits while the analog side recalibrates
      d.cnt = q.cnt - NW'(1);
      if (q.cnt == NW'(1)) begin
        d.done = 1'b1;
        d.result = adc_sample;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '{cnt: '0, done: 1'b1, result: 12'h000};
    end else begin
      q <= d;
    end
  end
  assign cif.done = q.done;
  assign cif.result = q.result;
  start_clears_a: assert property (@(posedge clk) disable iff (rst)
    cif.start |=> !cif.done) else $error("done not cleared");
  done_hold_a: assert property (@(posedge clk) disable iff (rst)
    (!cif.done && !cif.start && q.cnt > NW'(1)) |=> !cif.done)
    else $error("done set early");
endmodule
`default_nettype wire

// ===== logic/sis_conv_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sis_conv_if;
  logic start;
  logic [4:0] chan;
  logic calib_busy;
  logic done;
  logic [11:0] result;
  modport ctl (input start, chan, calib_busy, output done, result);
  modport host (output start, chan, calib_busy, input done, result);
endinterface
`default_nettype wire

// ===== logic/sis_pkg.sv
// Behaviour
// - Pin low, debug-port reset or serial reset command force all outputs to reset states
// - During reset, open-drain outputs and open-drain gate pins float
// - During reset, gate-driver pins actively pull low
// - After reset outputs resume configured states; sequence restarts at step one
// - After reset, calibration reruns; monitors busy up to 500 us
// - Reset mid-operation aborts everything, returns to power-on state
// - Answer only the own 7-bit slave address, set from configuration
// - Port is slave only; master makes SCL and runs transfers
// - Frames are 9 clocks; slave acknowledges on the ninth of written frames
// - Addresses and data travel most significant bit first
// - SDA changes only with SCL low; SDA rising with SCL high ends transaction
// - After address with read bit, slave shifts addressed register out
// - Any write to register 0x12 resets the whole device
// - Bits without function read back as 1
// - Supply status registers show both comparator flags of each input
// - Window mode input reports window result on its first flag
// - Support bus timeout and alert line features
// - All serial registers also reachable from the debug port; here the debug port only requests a device reset
// - Channel select write starts conversion; done bit 0 while busy, 1 after
// - Each output comes from sequencing logic or host values per pin choice
package sis_pkg;
  // Timing
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned CALIB_US = 500;
  localparam int unsigned CALIB_CYC = CALIB_US * CLK_MHZ;
  localparam int unsigned TIMEOUT_US = 25000;
  localparam int unsigned TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
  localparam int unsigned CONV_US = 100;
  localparam int unsigned CONV_CYC = CONV_US * CLK_MHZ;
  // Register offsets
  localparam logic [7:0] REG_CMP_A = 8'h00;
  localparam logic [7:0] REG_CMP_B = 8'h01;
  localparam logic [7:0] REG_CMP_C = 8'h02;
  localparam logic [7:0] REG_OUT_LO = 8'h03;
  localparam logic [7:0] REG_OUT_HI = 8'h04;
  localparam logic [7:0] REG_DIN = 8'h06;
  localparam logic [7:0] REG_RES_LO = 8'h07;
  localparam logic [7:0] REG_RES_HI = 8'h08;
  localparam logic [7:0] REG_CHAN = 8'h09;
  localparam logic [7:0] REG_SIG0 = 8'h0a;
  localparam logic [7:0] REG_SIG1 = 8'h0b;
  localparam logic [7:0] REG_SIG2 = 8'h0c;
  localparam logic [7:0] REG_SIG3 = 8'h0d;
  localparam logic [7:0] REG_GP_LO = 8'h0e;
  localparam logic [7:0] REG_GP_HI = 8'h0f;
  localparam logic [7:0] REG_OVR = 8'h11;
  localparam logic [7:0] REG_RESET = 8'h12;
  // Field positions and reset values
  localparam int unsigned CHAN_W = 5;
  localparam int unsigned OVR_LSB = 1;
  localparam logic [7:0] GP_LO_RST = 8'h04;
  localparam logic [5:0] GP_HI_RST = 6'h00;
  localparam logic [2:0] OVR_RST = 3'h0;
  localparam logic [4:0] CHAN_RST = 5'h00;
  localparam logic [7:0] UNMAPPED = 8'hff;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_ADDR = 4'h1, ST_ACK_ADDR = 4'h3, ST_REG = 4'h2,
    ST_ACK_REG = 4'h6, ST_DATA = 4'h7, ST_ACK_DATA = 4'h5,
    ST_RD = 4'h4, ST_RD_ACK = 4'hc
  } sis_bus_st_type;
endpackage

// ===== logic/sis_reg_slave.sv
`timescale 1ns/1ps
`default_nettype none
module sis_reg_slave
  import sis_pkg::*;
#(
  parameter int unsigned CALIB_CYCLES = CALIB_CYC,
  parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC,
  parameter int unsigned CONV_CYCLES = CONV_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Reset requests
  input wire logic hard_clear_pin_n,
  input wire logic jtag_reset_req,
  // Two-wire bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic smb_alert_out,
  output logic smb_alert_oe,
  // Configuration
  input wire logic [6:0] slave_addr,
  input wire logic [13:0] out_src_host,
  input wire logic [1:0] hv_fet_mode,
  input wire logic [9:0] window_mode,
  // Monitored state
  input wire logic [9:0] cmp_a,
  input wire logic [9:0] cmp_b,
  input wire logic [9:0] window_result,
  input wire logic [13:0] pld_outputs,
  input wire logic [3:0] digital_in,
  input wire logic [31:0] user_signature,
  input wire logic [11:0] adc_sample,
  // Pin drive
  output logic [11:0] open_drain_outputs_oe,
  output logic [1:0] gate_drive_outputs,
  output logic [1:0] gate_drive_outputs_oe,
  output logic [2:0] input_override,
  // System status
  output logic device_in_reset,
  output logic seq_restart,
  output logic calib_busy
);
  localparam int unsigned TW = $clog2(TIMEOUT_CYCLES + 1);
  localparam int unsigned CW = $clog2(CALIB_CYCLES + 1);
  typedef struct packed {
    sis_bus_st_type st;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic rw;
    logic [7:0] ptr;
    logic scl_p;
    logic sda_p;
    logic sda_oe;
    logic drive_lo;
    logic [TW-1:0] tout;
    logic [7:0] gp_lo;
    logic [5:0] gp_hi;
    logic [2:0] ovr;
    logic [4:0] chan;
    logic conv_start;
    logic soft_rst;
    logic alert;
    logic done_p;
    logic rst_act;
    logic seq_rst;
    logic [CW-1:0] calib;
    logic calib_busy;
    logic [11:0] od_oe;
    logic [1:0] hv_out;
    logic [1:0] hv_oe;
  } sis_top_state_type;
  sis_top_state_type q, d;
  logic [36:0] pins_s;
  logic clr_pin_s;
  logic scl_s;
  logic sda_s;
  logic [3:0] din_s;
  logic [9:0] cmp_a_s;
  logic [9:0] cmp_b_s;
  logic [9:0] win_s;
  logic [19:0] flags;
  logic [13:0] lvl;
  logic [13:0] gp_all;
  logic [7:0] rdata;
  logic dev_clr;
  logic start_c;
  logic stop_c;
  logic scl_rise;
  logic scl_fall;
  sis_conv_if cif ();
  // Pins and comparators come from outside this clock
  sis_sync #(.W(37)) u_sync (
    .clk(clk),
    .rst(rst),
    .d({hard_clear_pin_n, scl_in, sda_in, digital_in, cmp_a, cmp_b,
      window_result}),
    .q(pins_s)
  );
  assign clr_pin_s = pins_s[36];
  assign scl_s = pins_s[35];
  assign sda_s = pins_s[34];
  assign din_s = pins_s[33:30];
  assign cmp_a_s = pins_s[29:20];
  assign cmp_b_s = pins_s[19:10];
  assign win_s = pins_s[9:0];
  sis_adc_ctl #(.CONV_CYCLES(CONV_CYCLES)) u_adc (
    .clk(clk),
    .rst(dev_clr),
    .adc_sample(adc_sample),
    .cif(cif)
  );
  assign cif.start = q.conv_start;
  assign cif.chan = q.chan;
  assign cif.calib_busy = q.calib_busy;
  // Every source ends in the same full clear of the device
  assign dev_clr = rst | ~clr_pin_s | jtag_reset_req | q.soft_rst;
  assign scl_rise = scl_s & ~q.scl_p;
  assign scl_fall = ~scl_s & q.scl_p;
  assign start_c = scl_s & q.scl_p & q.sda_p & ~sda_s;
  assign stop_c = scl_s & q.scl_p & ~q.sda_p & sda_s;
  for (genvar i = 0; i < 10; i++) begin : g_flags
    assign flags[2*i] = window_mode[i] ? win_s[i] : cmp_a_s[i];
    assign flags[2*i+1] = cmp_b_s[i];
  end
  assign gp_all = {q.gp_hi, q.gp_lo};
  for (genvar j = 0; j < 14; j++) begin : g_lvl
    assign lvl[j] = out_src_host[j] ? gp_all[j]
      : pld_outputs[j];
  end
  // Read data; unused bits and unmapped offsets read as ones
  always_comb begin
    case (q.ptr)
      REG_CMP_A: rdata = flags[7:0];
      REG_CMP_B: rdata = flags[15:8];
      REG_CMP_C: rdata = {4'hf, flags[19:16]};
      REG_OUT_LO: rdata = lvl[7:0];
      REG_OUT_HI: rdata = {2'h3, lvl[13:8]};
      REG_DIN: rdata = {4'hf, din_s};
      REG_RES_LO: rdata = {cif.result[3:0], 3'h7, cif.done};
      REG_RES_HI: rdata = cif.result[11:4];
      REG_CHAN: rdata = {3'h7, q.chan};
      REG_SIG0: rdata = user_signature[7:0];
      REG_SIG1: rdata = user_signature[15:8];
      REG_SIG2: rdata = user_signature[23:16];
      REG_SIG3: rdata = user_signature[31:24];
      REG_GP_LO: rdata = q.gp_lo;
      REG_GP_HI: rdata = {2'h3, q.gp_hi};
      REG_OVR: rdata = {4'hf, q.ovr, 1'b1};
      default: rdata = UNMAPPED;
    endcase
  end
  always_comb begin
    d = q;
    d.scl_p = scl_s;
    d.sda_p = sda_s;
    d.conv_start = 1'b0;
    d.soft_rst = 1'b0;
    d.seq_rst = 1'b0;
    d.done_p = cif.done;
    // Slave only: SCL is never driven, SDA only pulled low
    if (start_c) begin
      d.st = ST_ADDR;
      d.bitcnt = 4'h0;
      d.sda_oe = 1'b0;
    end else if (stop_c) begin
      d.st = ST_IDLE;
      d.sda_oe = 1'b0;
    end else if (scl_rise) begin
      case (q.st)
        ST_ADDR, ST_REG, ST_DATA: begin
          d.shreg = {q.shreg[6:0], sda_s};
          d.bitcnt = q.bitcnt + 4'h1;
        end
        ST_RD_ACK: begin
          // Master acknowledge clock ends the read, its value unused; one byte per read
          d.st = ST_IDLE;
        end
        default: begin
          d.st = q.st;
        end
      endcase
    end else if (scl_fall) begin
      case (q.st)
        ST_ADDR: begin
          if (q.bitcnt == 4'h8) begin
            if (q.shreg[7:1] == slave_addr) begin
              d.st = ST_ACK_ADDR;
              d.sda_oe = 1'b1;
              d.rw = q.shreg[0];
            end else begin
              d.st = ST_IDLE;
            end
          end
        end
        ST_ACK_ADDR: begin
          d.bitcnt = 4'h0;
          if (q.rw) begin
            d.st = ST_RD;
            d.shreg = rdata;
            d.sda_oe = ~rdata[7];
            if (q.ptr == REG_RES_LO) begin
              d.alert = 1'b0;
            end
          end else begin
            d.st = ST_REG;
            d.sda_oe = 1'b0;
          end
        end
        ST_REG: begin
          if (q.bitcnt == 4'h8) begin
            d.ptr = q.shreg;
            d.st = ST_ACK_REG;
            d.sda_oe = 1'b1;
          end
        end
        ST_ACK_REG: begin
          d.st = ST_DATA;
          d.bitcnt = 4'h0;
          d.sda_oe = 1'b0;
        end
        ST_DATA: begin
          if (q.bitcnt == 4'h8) begin
            d.st = ST_ACK_DATA;
            d.sda_oe = 1'b1;
            case (q.ptr)
              REG_CHAN: begin
                d.chan = q.shreg[CHAN_W-1:0];
                d.conv_start = 1'b1;
              end
              REG_GP_LO: d.gp_lo = q.shreg;
              REG_GP_HI: d.gp_hi = q.shreg[5:0];
              REG_OVR: d.ovr = q.shreg[OVR_LSB+2:OVR_LSB];
              default: d.gp_lo = q.gp_lo;
            endcase
          end
        end
        ST_ACK_DATA: begin
          d.st = ST_IDLE;
          d.sda_oe = 1'b0;
          // Reset after the acknowledge so the master sees it taken
          d.soft_rst = (q.ptr == REG_RESET);
        end
        ST_RD: begin
          if (q.bitcnt == 4'h7) begin
            d.st = ST_RD_ACK;
            d.sda_oe = 1'b0;
          end else begin
            d.shreg = {q.shreg[6:0], 1'b0};
            d.sda_oe = ~q.shreg[6];
            d.bitcnt = q.bitcnt + 4'h1;
          end
        end
        default: begin
          d.st = q.st;
        end
      endcase
    end
    // Bus timeout frees a stuck transfer; SCL high clears the count
    if (scl_s || q.st == ST_IDLE) begin
      d.tout = '0;
    end else if (q.tout == TW'(TIMEOUT_CYCLES - 1)) begin
      d.tout = '0;
      d.st = ST_IDLE;
      d.sda_oe = 1'b0;
    end else begin
      d.tout = q.tout + TW'(1);
    end
    // Alert set on conversion end; set wins over the read clear
    if (cif.done && !q.done_p) begin
      d.alert = 1'b1;
    end
    if (q.calib != '0) begin
      d.calib = q.calib - CW'(1);
      d.calib_busy = (q.calib != CW'(1));
    end
    if (q.rst_act) begin
      d.rst_act = 1'b0;
      d.seq_rst = 1'b1;
      d.calib = CW'(CALIB_CYCLES);
      d.calib_busy = 1'b1;
    end
    d.od_oe = ~lvl[13:2];
    d.hv_oe = hv_fet_mode | ~lvl[1:0];
    d.hv_out = hv_fet_mode & lvl[1:0];
    if (dev_clr) begin
      // Aborts everything in flight, back to power-on state
      d = '0;
      d.st = ST_IDLE;
      d.scl_p = 1'b1;
      d.sda_p = 1'b1;
      d.gp_lo = GP_LO_RST;
      d.gp_hi = GP_HI_RST;
      d.ovr = OVR_RST;
      d.chan = CHAN_RST;
      d.done_p = 1'b1;
      d.rst_act = 1'b1;
      d.calib_busy = 1'b1;
      d.od_oe = 12'h000;
      d.hv_oe = hv_fet_mode;
      d.hv_out = 2'h0;
    end
  end
  always_ff @(posedge clk) begin
    q <= d;
  end
  assign sda_out = q.drive_lo;
  assign sda_oe = q.sda_oe;
  assign smb_alert_out = q.drive_lo;
  assign smb_alert_oe = q.alert;
  assign open_drain_outputs_oe = q.od_oe;
  assign gate_drive_outputs = q.hv_out;
  assign gate_drive_outputs_oe = q.hv_oe;
  assign input_override = q.ovr;
  assign device_in_reset = q.rst_act;
  assign seq_restart = q.seq_rst;
  assign calib_busy = q.calib_busy;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  reset_float_a: assert property (dev_clr |=> (open_drain_outputs_oe == 12'h000
    && (gate_drive_outputs_oe & ~$past(hv_fet_mode)) == 2'h0 && device_in_reset))
    else $error("outputs not floated in reset");
  reset_pull_a: assert property (dev_clr |=> ((gate_drive_outputs_oe
    & ~gate_drive_outputs) == $past(hv_fet_mode)))
    else $error("gate pins not pulled low");
  restart_pulse_a: assert property ((device_in_reset && !dev_clr) |=>
    (seq_restart && calib_busy && !device_in_reset) ##1 !seq_restart)
    else $error("no restart after reset");
  calib_hold_a: assert property (seq_restart |-> calib_busy [*8])
    else $error("calibration window too short");
  addr_reject_a: assert property ((q.st == ST_ADDR && scl_fall && !start_c
    && !stop_c && q.bitcnt == 4'h8 && q.shreg[7:1] != slave_addr
    && !dev_clr) |=> (!sda_oe && q.st == ST_IDLE))
    else $error("acked foreign address");
  ack_drive_a: assert property ((q.st inside {ST_ACK_ADDR, ST_ACK_REG,
    ST_ACK_DATA}) |-> sda_oe) else $error("ack not driven");
  stop_idle_a: assert property ((stop_c && !dev_clr) |=>
    (q.st == ST_IDLE && !sda_oe)) else $error("stop not honoured");
  read_msb_a: assert property ((q.st == ST_ACK_ADDR && q.rw && scl_fall
    && !start_c && !stop_c && !dev_clr) |=> (sda_oe == !$past(rdata[7])))
    else $error("read msb wrong");
  soft_reset_a: assert property ((q.st == ST_ACK_DATA && q.ptr == REG_RESET
    && scl_fall && !start_c && !stop_c) |-> ##2 device_in_reset)
    else $error("reset write ignored");
  ptr_keep_a: assert property ((q.st == ST_IDLE && !dev_clr) |=>
    q.ptr == $past(q.ptr)) else $error("pointer lost");
  write_done_c: cover property (q.st == ST_ACK_DATA && scl_fall);
  read_done_c: cover property (q.st == ST_RD_ACK && scl_rise);
  soft_reset_c: cover property (q.soft_rst);
  timeout_c: cover property (q.tout == TW'(TIMEOUT_CYCLES - 1) && !scl_s);
endmodule
`default_nettype wire

// ===== logic/sis_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sis_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sis_sync_state_type;
  sis_sync_state_type r_q, r_d;
  always_comb begin
    r_d.s1 = d;
    r_d.s2 = r_q.s1;
  end
  // Idle-high reset suits the bus lines and the active-low clear pin
  always_ff @(posedge clk) begin
    if (rst) begin
      r_q <= '1;
    end else begin
      r_q <= r_d;
    end
  end
  assign q = r_q.s2;
endmodule
`default_nettype wire

// ===== verif/sis_bus_master.sv
`timescale 1ns/1ps
`default_nettype none
module sis_bus_master (
  // Clock
  input wire logic clk,
  // Bus wire
  input wire logic sda_line,
  output logic scl,
  output logic sda_pull
);
  // Bits of 12 and 13 clk alternate, 125 ns on average
  localparam int HALF = 6;
  logic odd;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    odd = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic start_cond();
    sda_pull <= 1'b1;
    tick(HALF);
    scl <= 1'b0;
    tick(HALF / 2);
  endtask
  // Data moves only in the low phase
  task automatic put_bit(input logic b, output logic s);
    sda_pull <= ~b;
    tick(HALF / 2);
    scl <= 1'b1;
    tick(HALF + int'(odd));
    odd = ~odd;
    s = sda_line;
    scl <= 1'b0;
    tick(HALF / 2);
  endtask
  task automatic stop_cond();
    sda_pull <= 1'b1;
    tick(HALF / 2);
    scl <= 1'b1;
    tick(HALF);
    sda_pull <= 1'b0;
    tick(HALF);
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i], s);
    end
    put_bit(1'b1, s);
    ack = ~s;
  endtask
  task automatic recv_byte(output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, s);
      d[i] = s;
    end
    put_bit(1'b1, s);
  endtask
  task automatic write_reg(input logic [6:0] a, input logic [7:0] r,
                           input logic [7:0] v, output logic ok);
    logic k0, k1, k2;
    start_cond();
    send_byte({a, 1'b0}, k0);
    send_byte(r, k1);
    send_byte(v, k2);
    stop_cond();
    ok = k0 & k1 & k2;
  endtask
  task automatic read_reg(input logic [6:0] a, input logic [7:0] r,
                          output logic [7:0] d, output logic ok);
    logic k0, k1, k2;
    start_cond();
    send_byte({a, 1'b0}, k0);
    send_byte(r, k1);
    stop_cond();
    start_cond();
    send_byte({a, 1'b1}, k2);
    recv_byte(d);
    stop_cond();
    ok = k0 & k1 & k2;
  endtask
endmodule
`default_nettype wire

// ===== verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
  import sis_pkg::*;
;
  // Address kept clear of the reserved ranges
  localparam logic [6:0] OWN_ADDR = 7'h3a;
  localparam int CALIB_SIM = 20;
  localparam logic [9:0] WIN_MODE = 10'h201;
  localparam logic [9:0] CMP_A_V = 10'h2b6;
  localparam logic [9:0] CMP_B_V = 10'h1c9;
  localparam logic [9:0] WIN_RES = 10'h001;
  localparam logic [31:0] SIG = 32'h5a3c_96e1;
  logic clk, rst, hard_clear_pin_n, jtag_reset_req, scl, sda_pull;
  wire logic sda_line;
  logic sda_out, sda_oe, smb_alert_out, smb_alert_oe;
  logic [13:0] out_src_host, pld_outputs;
  logic [9:0] cmp_a, cmp_b, window_result;
  logic [11:0] adc_sample, open_drain_outputs_oe;
  logic [1:0] gate_drive_outputs, gate_drive_outputs_oe;
  logic [2:0] input_override;
  logic device_in_reset, seq_restart, calib_busy;
  int n_mismatch = 0;
  int comparisons = 0;
  int n_restart = 0;
  // Open-drain wire with pull-up
  assign sda_line = ~(sda_pull | sda_oe);
  sis_bus_master sis_bus_master_inst (.clk(clk), .sda_line(sda_line),
    .scl(scl), .sda_pull(sda_pull));
  sis_reg_slave #(.CALIB_CYCLES(CALIB_SIM), .TIMEOUT_CYCLES(200),
    .CONV_CYCLES(16)) sis_reg_slave_inst (.clk(clk), .rst(rst),
    .hard_clear_pin_n(hard_clear_pin_n), .jtag_reset_req(jtag_reset_req),
    .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .smb_alert_out(smb_alert_out), .smb_alert_oe(smb_alert_oe),
    .slave_addr(OWN_ADDR), .out_src_host(out_src_host),
    .hv_fet_mode(2'h1), .window_mode(WIN_MODE), .cmp_a(cmp_a),
    .cmp_b(cmp_b), .window_result(window_result),
    .pld_outputs(pld_outputs), .digital_in(4'h5), .user_signature(SIG),
    .adc_sample(adc_sample), .open_drain_outputs_oe(open_drain_outputs_oe),
    .gate_drive_outputs(gate_drive_outputs),
    .gate_drive_outputs_oe(gate_drive_outputs_oe),
    .input_override(input_override), .device_in_reset(device_in_reset),
    .seq_restart(seq_restart), .calib_busy(calib_busy));
  always @(posedge clk) if (seq_restart === 1'b1) n_restart++;
  task automatic chkv(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] r, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    sis_bus_master_inst.read_reg(OWN_ADDR, r, d, ok);
    chk1(ok, 1'b1);
    chkv({8'h00, d}, {8'h00, exp});
  endtask
  task automatic wr(input logic [7:0] r, input logic [7:0] v);
    logic ok;
    sis_bus_master_inst.write_reg(OWN_ADDR, r, v, ok);
    chk1(ok, 1'b1);
  endtask
  // Gate 0 is a driver, gate 1 open drain
  task automatic chk_pins(input logic [13:0] lv);
    chkv({4'h0, open_drain_outputs_oe}, {4'h0, ~lv[13:2]});
    chkv({14'h0, gate_drive_outputs_oe}, {14'h0, ~lv[1], 1'b1});
    chk1(gate_drive_outputs[0], lv[0]);
  endtask
  task automatic t_defaults();
    rd_chk(REG_GP_LO, 8'h04);
    rd_chk(REG_GP_HI, 8'hc0);
    rd_chk(REG_OVR, 8'hf1);
    rd_chk(8'h05, 8'hff);
    rd_chk(REG_RES_LO, 8'h0f);
    rd_chk(REG_CHAN, 8'he0);
    for (int i = 0; i < 4; i++) begin
      rd_chk(REG_SIG0 + 8'(i), SIG[8 * i +: 8]);
    end
  endtask
  task automatic t_addr();
    logic ok;
    sis_bus_master_inst.write_reg(OWN_ADDR ^ 7'h01, REG_GP_LO, 8'h00, ok);
    chk1(ok, 1'b0);
    rd_chk(REG_GP_LO, 8'h04);
  endtask
  task automatic t_status();
    logic [23:0] f;
    cmp_a <= CMP_A_V;
    cmp_b <= CMP_B_V;
    window_result <= WIN_RES;
    f = 24'hf0_0000;
    for (int i = 0; i < 10; i++) begin
      f[2 * i] = WIN_MODE[i] ? WIN_RES[i] : CMP_A_V[i];
      f[2 * i + 1] = CMP_B_V[i];
    end
    rd_chk(REG_CMP_A, f[7:0]);
    rd_chk(REG_CMP_B, f[15:8]);
    rd_chk(REG_CMP_C, f[23:16]);
    rd_chk(REG_DIN, 8'hf5);
  endtask
  task automatic t_outputs();
    pld_outputs <= 14'h2a5c;
    repeat (6) @(posedge clk);
    chk_pins(14'h2a5c);
    rd_chk(REG_OUT_LO, 8'h5c);
    rd_chk(REG_OUT_HI, 8'hea);
    out_src_host <= 14'h3fff;
    wr(REG_GP_LO, 8'ha3);
    wr(REG_GP_HI, 8'h15);
    wr(REG_OUT_LO, 8'h00);
    chk_pins(14'h15a3);
    rd_chk(REG_OUT_LO, 8'ha3);
    rd_chk(REG_GP_HI, 8'hd5);
    wr(REG_OVR, 8'h0a);
    chkv({13'h0, input_override}, {13'h0, 3'h5});
    rd_chk(REG_OVR, 8'hfb);
  endtask
  task automatic t_conv();
    int k;
    adc_sample <= 12'habc;
    wr(REG_CHAN, 8'h0b);
    k = 0;
    while (smb_alert_oe !== 1'b1 && k < 200) begin
      @(posedge clk);
      k++;
    end
    chk1(smb_alert_oe, 1'b1);
    chkv({14'h0, sda_out, smb_alert_out}, 16'h0000);
    rd_chk(REG_CHAN, 8'heb);
    rd_chk(REG_RES_LO, 8'hcf);
    chk1(smb_alert_oe, 1'b0);
    rd_chk(REG_RES_HI, 8'hab);
  endtask
  // Sources: 0 clear pin, 1 debug-port request, 2 register write
  task automatic t_reset(input int src);
    int base;
    int k;
    wr(REG_GP_LO, 8'h00);
    wr(REG_GP_HI, 8'h00);
    chk_pins(14'h0000);
    base = n_restart;
    if (src == 0) hard_clear_pin_n <= 1'b0;
    if (src == 1) jtag_reset_req <= 1'b1;
    if (src < 2) begin
      repeat (8) @(posedge clk);
      chk1(device_in_reset, 1'b1);
      chkv({4'h0, open_drain_outputs_oe}, 16'h0000);
      chkv({14'h0, gate_drive_outputs_oe}, 16'h0001);
      chk1(gate_drive_outputs[0], 1'b0);
      hard_clear_pin_n <= 1'b1;
      jtag_reset_req <= 1'b0;
    end else begin
      wr(REG_RESET, 8'h00);
    end
    k = 0;
    while (calib_busy !== 1'b0 && k < 100) begin
      @(posedge clk);
      k++;
    end
    chk1(calib_busy, 1'b0);
    if (src < 2) chk1(k >= CALIB_SIM && k <= CALIB_SIM + 6, 1'b1);
    chkv(16'(n_restart - base), 16'h0001);
    chk_pins(14'h0004);
    rd_chk(REG_GP_LO, 8'h04);
  endtask
  // Master stalls with SCL low in the read frame
  task automatic t_timeout();
    logic a;
    sis_bus_master_inst.start_cond();
    sis_bus_master_inst.send_byte({OWN_ADDR, 1'b1}, a);
    chk1(a, 1'b1);
    repeat (8) @(posedge clk);
    chk1(sda_oe, 1'b1);
    repeat (260) @(posedge clk);
    chk1(sda_oe, 1'b0);
    sis_bus_master_inst.stop_cond();
    rd_chk(REG_GP_LO, 8'h04);
  endtask
  task automatic wrap_up();
    $display("Mismatches %0d of %0d comparisons", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #1_000_000;
    n_mismatch++;
    wrap_up();
  end
  initial begin
    rst = 1'b1;
    hard_clear_pin_n = 1'b1;
    jtag_reset_req = 1'b0;
    out_src_host = 14'h0000;
    pld_outputs = 14'h0000;
    cmp_a = 10'h000;
    cmp_b = 10'h000;
    window_result = 10'h000;
    adc_sample = 12'h000;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (CALIB_SIM + 10) @(posedge clk);
    t_defaults();
    t_addr();
    t_status();
    t_outputs();
    t_conv();
    for (int s = 0; s < 3; s++) begin
      t_reset(s);
    end
    t_timeout();
    wrap_up();
  end
endmodule
`default_nettype wire
